// File: src/irq_scan_pkg.sv
// Constants, register map and carrier types of the priority interrupt scanner.
// Assumes a 125 MHz system clock and a 15-bit core word address.
package irq_scan_pkg;

    localparam int          NUM_LINES      = 28;
    localparam int          IDX_W          = 5;
    localparam int          ADDR_W         = 15;
    localparam int          WORD_W         = 28;
    localparam int          OPC_W          = WORD_W - ADDR_W;

    // Priority position used when no line qualifies; it ranks below every real line.
    localparam logic [4:0]  LINE_NONE      = 5'h1F;
    localparam logic [4:0]  LINE_LAST      = 5'h1B;

    // Vector area: one resume/response pair per line, 56 words in all.
    localparam logic [14:0] VEC_BASE       = 15'o37400;
    localparam int          VEC_WORDS      = 56;

    // Holding register geometry.
    localparam int          HOLD_MIN_W     = 10;
    localparam int          HOLD_EXT_LO    = 4;
    localparam int          HOLD_EXT_HI    = 7;
    localparam logic [27:0] HOLD_EXT_BITS  = 28'h00000F0;

    // Lines with fixed types: elapsed time and drum end are pulse lines,
    // transfer complete and the two parity errors are level lines.
    localparam logic [27:0] FIXED_PULSE    = 28'h0000003;
    localparam logic [27:0] FIXED_LEVEL    = 28'h000001C;

    // Timing.
    localparam int          CLK_MHZ        = 125;
    localparam int          SCAN_TIME_US   = 18;
    localparam int          SCAN_LIMIT_CYC = SCAN_TIME_US * CLK_MHZ;
    localparam int          PULSE_MIN_US   = 12;
    localparam int          PULSE_MIN_CYC  = PULSE_MIN_US * CLK_MHZ;

    // APB register byte addresses.
    localparam logic [7:0]  OFS_MASK       = 8'h00;
    localparam logic [7:0]  OFS_HOLD       = 8'h04;
    localparam logic [7:0]  OFS_CTRL       = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;
    localparam logic [7:0]  OFS_PENDING    = 8'h10;
    localparam logic [7:0]  OFS_INSERVICE  = 8'h14;

    // Field positions and reset values.
    localparam int          CTRL_INHIBIT   = 0;
    localparam logic        CTRL_INHIBIT_RST = 1'b1;
    localparam logic [27:0] MASK_RST       = 28'h0000000;
    localparam logic [27:0] HOLD_RST       = 28'h0000000;
    localparam int          ST_ACTIVE_LSB  = 0;
    localparam int          ST_BUSY        = 5;
    localparam int          ST_REQUEST     = 6;
    localparam int          ST_BEST_LSB    = 8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAVE = 3'b010,
        ST_JUMP = 3'b100
    } vec_state_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } mem_write_t;

    typedef struct packed {
        logic              force_fetch;
        logic [ADDR_W-1:0] addr;
    } fetch_redirect_t;

endpackage

// File: src/line_sync.sv
// Three-stage synchroniser bank for the interrupt source pins.
// Assumes the pins are asynchronous to sys_clk; the filtered level moves
// only once the second and third stages agree.
`timescale 1ns/100ps
module line_sync #(
    parameter int WIDTH = 28
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
    wire  [WIDTH-1:0] level_d = (agree & s3_q) | (~agree & level_q);

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            level_q <= '0;
        end else begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_out = level_q;
endmodule

// File: src/priority_interrupt_scanner.sv
// Priority interrupt scanner: scans 28 lines, latches pulse lines, masks,
// picks the highest line and vectors the processor through core memory.
// Assumes an APB master, a processor that marks instruction boundaries and
// stalls on cpu_hold, and a core memory port that acknowledges writes.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module priority_interrupt_scanner
    import irq_scan_pkg::*;
#(
    parameter int                        HOLD_WIDTH    = 10,
    parameter logic [27:0]               LINE_IS_PULSE = 28'h0000003,
    parameter logic [irq_scan_pkg::OPC_W-1:0] JUMP_OPCODE = 13'h0001
) (
    input  wire logic                             sys_clk,
    input  wire logic                             reset,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [7:0]                       paddr,
    input  wire logic [31:0]                      pwdata,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [irq_scan_pkg::NUM_LINES-1:0] irq_line,
    input  wire logic                             cpu_instr_done,
    input  wire logic [irq_scan_pkg::ADDR_W-1:0]  cpu_next_addr,
    output logic                                  int_request,
    output logic                                  cpu_hold,
    output irq_scan_pkg::mem_write_t              mem_wr,
    input  wire logic                             mem_wr_ack,
    output irq_scan_pkg::fetch_redirect_t         fetch,
    output logic      [3:0]                       mem_ext_sel
);
    import irq_scan_pkg::*;

    function automatic logic [4:0] first_set(input logic [27:0] v);
        logic [4:0] r;
        r = LINE_NONE;
        for (int i = NUM_LINES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [14:0] resume_addr(input logic [4:0] idx);
        return 15'(VEC_BASE + {9'h000, idx, 1'b0});
    endfunction

    // Pulse lines latch into the hold bit of the same position; positions at
    // or above the hold width and the memory-extension bits cannot latch.
    localparam logic [27:0] HOLD_WIDTH_MASK = 28'((64'h1 << HOLD_WIDTH) - 64'h1);
    localparam logic [27:0] LATCH_MAP =
        ((LINE_IS_PULSE & ~FIXED_LEVEL) | FIXED_PULSE) & HOLD_WIDTH_MASK & ~HOLD_EXT_BITS;

    logic [27:0] line_level;
    logic [27:0] line_prev_q;
    logic [27:0] mask_q;
    logic [27:0] hold_q;
    logic [27:0] hold_d;
    logic        inhibit_q;
    logic [4:0]  scan_pos_q;
    logic [27:0] scan_acc_q;
    logic [27:0] pending_q;
    logic [27:0] in_service_q;
    logic [27:0] in_service_d;
    logic [4:0]  line_q;
    logic [14:0] resume_q;
    logic [31:0] prdata_q;
    vec_state_t  state_q;
    vec_state_t  state_d;

    line_sync #(
        .WIDTH (NUM_LINES)
    ) u_sync (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .pin_in    (irq_line),
        .level_out (line_level)
    );

    // Bus decode.
    wire         bus_setup   = psel && !penable;
    wire         bus_wr      = psel && penable && pwrite;
    wire         hit_mask    = paddr == OFS_MASK;
    wire         hit_hold    = paddr == OFS_HOLD;
    wire         hit_ctrl    = paddr == OFS_CTRL;
    wire         hit_status  = paddr == OFS_STATUS;
    wire         hit_pending = paddr == OFS_PENDING;
    wire         hit_insvc   = paddr == OFS_INSERVICE;
    wire         hit_any     = hit_mask | hit_hold | hit_ctrl | hit_status
                               | hit_pending | hit_insvc;

    // Pulse capture: a rising filtered level sets its hold bit.
    wire  [27:0] pulse_rise  = line_level & ~line_prev_q;
    wire  [27:0] hold_set    = pulse_rise & LATCH_MAP;
    // Write one to clear a latch bit; the extension bits take the written value.
    wire  [27:0] hold_clr    = (bus_wr && hit_hold) ? (pwdata[27:0] & LATCH_MAP) : 28'h0000000;

    // Scan source: level lines read straight from the synchroniser, pulse lines from hold.
    wire  [27:0] scan_src    = (line_level & ~LATCH_MAP) | (hold_q & LATCH_MAP);
    wire         scan_last   = scan_pos_q == LINE_LAST;

    // Selection.
    wire  [27:0] eligible    = pending_q & mask_q;
    wire  [4:0]  best_idx    = first_set(eligible);
    wire  [4:0]  active_idx  = first_set(in_service_q);
    wire         req_raw     = (best_idx < active_idx) && !inhibit_q;
    wire         accept      = (state_q == ST_IDLE) && req_raw && cpu_instr_done;
    wire         returning   = (state_q == ST_IDLE) && cpu_instr_done
                               && (active_idx != LINE_NONE)
                               && (cpu_next_addr == resume_addr(active_idx));

    always_comb begin
        hold_d = (hold_q & ~hold_clr) | hold_set;
        if (bus_wr && hit_hold) begin
            hold_d[HOLD_EXT_HI:HOLD_EXT_LO] = pwdata[HOLD_EXT_HI:HOLD_EXT_LO];
        end
        hold_d = hold_d & (HOLD_WIDTH_MASK | HOLD_EXT_BITS);
    end

    // A return is recognised by the next address matching the active resume word,
    // since the end of a response routine is otherwise invisible here.
    always_comb begin
        in_service_d = in_service_q;
        if (returning) begin
            in_service_d[active_idx] = 1'b0;
        end
        if (accept) begin
            in_service_d[best_idx] = 1'b1;
        end
    end

    always_comb begin
        case (state_q)
            ST_IDLE: state_d = accept ? ST_SAVE : ST_IDLE;
            ST_SAVE: state_d = mem_wr_ack ? ST_JUMP : ST_SAVE;
            ST_JUMP: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // Read data is captured in the setup cycle so that it comes from a flip-flop.
    wire  [31:0] rd_mux =
        hit_mask    ? {4'h0, mask_q} :
        hit_hold    ? {4'h0, hold_q} :
        hit_ctrl    ? {31'h00000000, inhibit_q} :
        hit_status  ? {19'h00000, best_idx, 1'b0, req_raw, active_idx != LINE_NONE,
                       active_idx} :
        hit_pending ? {4'h0, pending_q} :
        hit_insvc   ? {4'h0, in_service_q} : 32'h00000000;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mask_q    <= MASK_RST;
            hold_q    <= HOLD_RST;
            inhibit_q <= CTRL_INHIBIT_RST;
        end else begin
            if (bus_wr && hit_mask) begin
                mask_q <= pwdata[27:0];
            end
            if (bus_wr && hit_ctrl) begin
                inhibit_q <= pwdata[CTRL_INHIBIT];
            end
            hold_q <= hold_d;
        end
    end

    // One position per clock; a full pass takes 28 cycles, far inside the limit.
    // Pending lags a source by up to two passes, so a level source dropped by its
    // routine should stay low for two passes before the routine returns.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            scan_pos_q <= 5'h00;
            scan_acc_q <= 28'h0000000;
            pending_q  <= 28'h0000000;
        end else begin
            scan_pos_q <= scan_last ? 5'h00 : 5'(scan_pos_q + 5'h01);
            if (scan_last) begin
                pending_q  <= scan_acc_q | (scan_src & (28'h0000001 << LINE_LAST));
                scan_acc_q <= 28'h0000000;
            end else begin
                scan_acc_q <= scan_acc_q | (scan_src & (28'h0000001 << scan_pos_q));
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q      <= ST_IDLE;
            in_service_q <= 28'h0000000;
            line_q       <= LINE_NONE;
            resume_q     <= 15'h0000;
            line_prev_q  <= 28'h0000000;
            prdata_q     <= 32'h00000000;
        end else begin
            state_q      <= state_d;
            in_service_q <= in_service_d;
            line_prev_q  <= line_level;
            if (accept) begin
                line_q   <= best_idx;
                resume_q <= cpu_next_addr;
            end
            if (bus_setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    // Every register answers at once, so no wait state is ever inserted.
    assign prdata            = prdata_q;
    assign pready            = 1'b1;
    assign pslverr           = psel && penable && !hit_any;
    assign int_request       = req_raw;
    assign cpu_hold          = state_q != ST_IDLE;
    assign mem_wr.req        = state_q == ST_SAVE;
    assign mem_wr.addr       = resume_addr(line_q);
    assign mem_wr.data       = {JUMP_OPCODE, resume_q};
    assign fetch.force_fetch = state_q == ST_JUMP;
    assign fetch.addr        = 15'(resume_addr(line_q) + 15'h0001);
    assign mem_ext_sel       = hold_q[HOLD_EXT_HI:HOLD_EXT_LO];

    // Fixed-type reserved lines: first two pulse, next three level.
    wire [27:0] fixed_check = LATCH_MAP & (FIXED_PULSE | FIXED_LEVEL);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_saved;
        state_q == ST_SAVE && mem_wr_ack;
    endsequence

    sequence s_redirect;
        fetch.force_fetch && state_q == ST_JUMP;
    endsequence

    AST_SCAN_PERIOD: assert property (
        scan_pos_q == 5'h00 |-> ##28 scan_pos_q == 5'h00)
        else $error("Scan pass did not take 28 cycles.");

    AST_RESUME_WORD: assert property (
        accept |=> mem_wr.req && mem_wr.data == {JUMP_OPCODE, $past(cpu_next_addr)})
        else $error("Resume word lost the interrupted address.");

    AST_RESUME_ADDR: assert property (
        mem_wr.req |-> mem_wr.addr == 15'(VEC_BASE + {9'h000, line_q, 1'b0}))
        else $error("Resume word written to the wrong address.");

    AST_FORCE_FETCH: assert property (
        s_saved ##1 s_redirect |-> fetch.addr == 15'($past(mem_wr.addr) + 15'h0001))
        else $error("Forced fetch not from the second word of the pair.");

    AST_VEC_RANGE: assert property (
        fetch.force_fetch |-> fetch.addr >= 15'o37401 && fetch.addr <= 15'o37467)
        else $error("Response address outside the vector block.");

    AST_MASKED: assert property (
        accept |-> mask_q[best_idx] && pending_q[best_idx])
        else $error("Masked or idle line accepted.");

    AST_BOUNDARY: assert property (
        state_q == ST_IDLE ##1 state_q == ST_SAVE |-> $past(cpu_instr_done))
        else $error("Response began inside an instruction.");

    AST_INHIBIT: assert property (
        inhibit_q |-> !int_request ##1 (state_q != ST_SAVE || $past(state_q) != ST_IDLE))
        else $error("Request raised while inhibited.");

    AST_PREEMPT: assert property (
        int_request |-> best_idx < first_set(in_service_q) && mask_q[best_idx])
        else $error("Request without a higher enabled line.");

    AST_HOLD_SET: assert property (
        hold_set != 28'h0000000 |=> (hold_q & $past(hold_set)) == $past(hold_set))
        else $error("Pulse did not set its hold bit.");

    AST_HOLD_KEEP: assert property (
        hold_q[0] && !(bus_wr && hit_hold) |=> hold_q[0])
        else $error("Hold bit cleared without software.");

    AST_EXT_FREE: assert property (
        hold_set[HOLD_EXT_HI:HOLD_EXT_LO] == 4'h0 && fixed_check[4:2] == 3'h0)
        else $error("Reserved hold bits latched a pulse.");

    AST_REDIRECT: assert property (
        s_saved |=> s_redirect ##1 state_q == ST_IDLE)
        else $error("Fetch not forced right after the resume write.");

    AST_RESET_CLEAR: assert property (
        $fell(reset) |-> mask_q == MASK_RST && hold_q == HOLD_RST && inhibit_q)
        else $error("Reset left the mask, hold or inhibit live.");

    AST_WRITE_HOLD: assert property (
        mem_wr.req && !mem_wr_ack |=>
            mem_wr.req && $stable(mem_wr.data) && $stable(mem_wr.addr))
        else $error("Resume write dropped or changed before its acknowledge.");

    AST_RETURN: assert property (
        returning && !accept |=> !in_service_q[$past(active_idx)])
        else $error("Return did not release the active line.");

    AST_LEVEL_SCAN: assert property (
        scan_last |=> pending_q[LINE_LAST] == $past(scan_src[LINE_LAST]))
        else $error("Last position not taken straight from the scan.");

    AST_SCAN_BOUND: assert property (
        scan_pos_q <= LINE_LAST)
        else $error("Scan position ran past the last line.");

    AST_REQ_LIVE: assert property (
        int_request |-> !inhibit_q && (eligible & ~in_service_q) != 28'h0000000)
        else $error("Request with no uninhibited eligible line.");

    AST_HOLD_WIDTH: assert property (
        (hold_q & ~(HOLD_WIDTH_MASK | HOLD_EXT_BITS)) == 28'h0000000)
        else $error("Hold bit set above the configured width.");

endmodule

// File: bench/cpu_mem_model.sv
// Processor and core memory partner: marks instruction boundaries, stalls on
// cpu_hold and acknowledges resume-word writes after ack_wait extra cycles.
`timescale 1ns/100ps
module cpu_mem_model
    import irq_scan_pkg::*;
(
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          cpu_hold,
    input  wire irq_scan_pkg::mem_write_t      mem_wr,
    input  wire irq_scan_pkg::fetch_redirect_t fetch,
    input  wire logic [3:0]                    ack_wait,
    input  wire logic                          ret_req,
    input  wire logic [14:0]                   ret_addr,
    output logic                               mem_wr_ack,
    output logic                               cpu_instr_done,
    output logic      [14:0]                   cpu_next_addr,
    output logic      [14:0]                   last_pc,
    output logic      [14:0]                   wr_addr,
    output logic      [27:0]                   wr_data,
    output logic      [14:0]                   fetch_addr,
    output int                                 wr_cnt
);
    logic [27:0] vec_q [VEC_WORDS];
    logic [1:0]  gap_q;
    logic [3:0]  wait_q;
    logic        ret_q;
    logic [14:0] pc_q;
    wire  [14:0] ret_slot = ret_addr - VEC_BASE;
    wire  [14:0] wr_slot = mem_wr.addr - VEC_BASE;

    // The jump into the resume word is the routine's last instruction.
    assign cpu_next_addr = ret_q ? ret_addr : pc_q;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            {gap_q, cpu_instr_done, ret_q, wait_q, mem_wr_ack} <= '0;
            pc_q <= 15'h0100;
            {last_pc, wr_addr, wr_data, fetch_addr} <= '0;
            wr_cnt <= 0;
        end else begin
            gap_q <= cpu_hold ? gap_q : gap_q + 2'h1;
            cpu_instr_done <= !cpu_hold && gap_q == 2'h3;
            if (cpu_instr_done) begin
                last_pc <= cpu_next_addr;
                pc_q <= ret_q ? vec_q[ret_slot[5:0]][14:0] : pc_q + 15'h1;
                ret_q <= 1'b0;
            end
            if (ret_req)
                ret_q <= 1'b1;
            if (fetch.force_fetch) begin
                pc_q <= fetch.addr;
                fetch_addr <= fetch.addr;
            end
            mem_wr_ack <= mem_wr.req && !mem_wr_ack && wait_q >= ack_wait;
            wait_q <= (mem_wr.req && !mem_wr_ack) ? wait_q + 4'h1 : 4'h0;
            if (mem_wr.req && mem_wr_ack) begin
                vec_q[wr_slot[5:0]] <= mem_wr.data;
                wr_addr <= mem_wr.addr;
                wr_data <= mem_wr.data;
                wr_cnt <= wr_cnt + 1;
            end
        end
    end
endmodule

// File: bench/tb_priority_interrupt_scanner.sv
// Self-checking bench of the priority interrupt scanner.
// Assumes cpu_mem_model stands in for the processor and core memory.
`timescale 1ns/100ps
module tb_priority_interrupt_scanner;
    import irq_scan_pkg::*;

    // Arbitrary opcode, chosen so that it differs from the design's default.
    localparam logic [12:0] JUMP_OP = 13'h0ABC;

    logic            sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]      paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [27:0]     irq_line, wr_data;
    logic            cpu_instr_done, int_request, cpu_hold, mem_wr_ack, ret_req, err;
    logic [14:0]     cpu_next_addr, ret_addr, last_pc, wr_addr, fetch_addr;
    logic [3:0]      mem_ext_sel, ack_wait;
    mem_write_t      mem_wr;
    fetch_redirect_t fetch;
    int              wr_cnt, n_mismatch, checks;

    priority_interrupt_scanner #(.HOLD_WIDTH(10), .LINE_IS_PULSE(28'h000000F),
        .JUMP_OPCODE(JUMP_OP)) priority_interrupt_scanner_inst (
        .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_line(irq_line),
        .cpu_instr_done(cpu_instr_done), .cpu_next_addr(cpu_next_addr),
        .int_request(int_request), .cpu_hold(cpu_hold), .mem_wr(mem_wr),
        .mem_wr_ack(mem_wr_ack), .fetch(fetch), .mem_ext_sel(mem_ext_sel));

    cpu_mem_model cpu_mem_model_inst (
        .sys_clk(sys_clk), .reset(reset), .cpu_hold(cpu_hold), .mem_wr(mem_wr),
        .fetch(fetch), .ack_wait(ack_wait), .ret_req(ret_req), .ret_addr(ret_addr),
        .mem_wr_ack(mem_wr_ack), .cpu_instr_done(cpu_instr_done),
        .cpu_next_addr(cpu_next_addr), .last_pc(last_pc), .wr_addr(wr_addr),
        .wr_data(wr_data), .fetch_addr(fetch_addr), .wr_cnt(wr_cnt));

    always #4 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // The request stays put until pready is sampled high with penable.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string msg);
        apb(1'b0, a, 32'h0);
        check(rd, e, msg);
    endtask

    task automatic lines(input logic [27:0] v);
        @(posedge sys_clk);
        irq_line <= v;
    endtask

    task automatic no_vec(input int n);
        int n0;
        n0 = wr_cnt;
        repeat (n) @(posedge sys_clk);
        check(32'(wr_cnt - n0), 0, "unexpected vector");
    endtask

    // Bound covers the synchroniser, the 18 us scan time limit and an instruction.
    task automatic wait_vec(input int idx);
        int n0;
        n0 = wr_cnt;
        for (int i = 0; i < 2300 && wr_cnt == n0; i++)
            @(posedge sys_clk);
        repeat (2) @(posedge sys_clk);
        check(32'(wr_cnt - n0), 1, "one resume write");
        check(wr_addr, VEC_BASE + 15'(2 * idx), "resume address");
        check(wr_data, {JUMP_OP, last_pc}, "resume word");
        check(fetch_addr, VEC_BASE + 15'(2 * idx + 1), "response fetch");
    endtask

    task automatic ret(input logic [14:0] a);
        @(posedge sys_clk);
        ret_addr <= a;
        // Pending lags a dropped source by up to two scan passes.
        repeat (2 * NUM_LINES + 16) @(posedge sys_clk);
        ret_req <= 1'b1;
        @(posedge sys_clk);
        ret_req <= 1'b0;
        repeat (12) @(posedge sys_clk);
    endtask

    task automatic pulse(input logic [27:0] v);
        lines(v);
        repeat (PULSE_MIN_CYC) @(posedge sys_clk);
        lines(28'h0);
        repeat (2 * NUM_LINES + 16) @(posedge sys_clk);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        {sys_clk, psel, penable, pwrite, ret_req} = '0;
        {paddr, pwdata, irq_line, ret_addr, ack_wait} = '0;
        {n_mismatch, checks} = '0;
        reset = 1'b1;
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        rchk(OFS_MASK, 32'h0, "mask reset");
        rchk(OFS_HOLD, 32'h0, "hold reset");
        rchk(OFS_CTRL, 32'h1, "inhibit reset");
        apb(1'b0, 8'h18, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, OFS_MASK, 32'hFFFFFFFF);
        rchk(OFS_MASK, 32'h0FFFFFFF, "mask width");
        lines(28'h0000004);
        no_vec(100);
        check(int_request, 1'b0, "request while inhibited");
        apb(1'b1, OFS_MASK, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        no_vec(100);
        apb(1'b1, OFS_MASK, 32'h0800000C);
        lines(28'h8000004);
        wait_vec(2);
        lines(28'h8000000);
        apb(1'b1, OFS_MASK, 32'h0000000C);
        ret(VEC_BASE + 15'h4);
        apb(1'b1, OFS_MASK, 32'h0800000C);
        wait_vec(27);
        ack_wait <= 4'h5;
        lines(28'h8000008);
        wait_vec(3);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[5:0], 6'h23, "line 4 in service");
        lines(28'h8000000);
        ret(VEC_BASE + 15'h6);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[5:0], 6'h3B, "line 28 resumed");
        lines(28'h0);
        ret(VEC_BASE + 15'd54);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[5:0], 6'h1F, "nothing in service");
        ack_wait <= 4'h0;
        apb(1'b1, OFS_MASK, 32'h0);
        pulse(28'h0000002);
        rchk(OFS_HOLD, 32'h2, "pulse latched");
        apb(1'b1, OFS_HOLD, 32'h2);
        rchk(OFS_HOLD, 32'h0, "hold cleared");
        no_vec(2 * NUM_LINES + 16);
        apb(1'b1, OFS_MASK, 32'h2);
        lines(28'h0000002);
        wait_vec(1);
        pulse(28'h0000002);
        rchk(OFS_HOLD, 32'h2, "hold kept on accept");
        apb(1'b1, OFS_HOLD, 32'h2);
        ret(VEC_BASE + 15'h2);
        no_vec(80);
        apb(1'b1, OFS_HOLD, 32'h000000F0);
        rchk(OFS_HOLD, 32'h000000F0, "extension bits");
        check(mem_ext_sel, 4'hF, "extension select");
        pulse(28'h0000020);
        apb(1'b1, OFS_MASK, 32'h20);
        no_vec(40);
        lines(28'h0000020);
        wait_vec(5);
        lines(28'h0);
        ret(VEC_BASE + 15'hA);
        rchk(OFS_HOLD, 32'h000000F0, "extension not latched");
        apb(1'b1, OFS_HOLD, 32'h0);
        @(posedge sys_clk);
        check(mem_ext_sel, 4'h0, "extension cleared");
        results;
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        results;
    end
endmodule
